// *** ptp_cfg.svh ***
`ifndef PTP_CFG_SVH
`define PTP_CFG_SVH

`define PTP_ADDR_LSB       10
`define PTP_ADDR_MSB       21
`define PTP_RD_STROBE_BIT  22
`define PTP_WR_STROBE_BIT  23
`define PTP_SEL_BIT        24
`define PTP_BUS_LSB        16
`define PTP_BUS_MSB        31
`define PTP_ADDR_W         12
`define PTP_DATA_W         16
`define PTP_LINK_W         32
`define PTP_TX_RESET       32'hffffffff
`define PTP_OE_RESET       32'hffffffff
`define PTP_DEPTH_DEFAULT  16

`endif

// *** ptp_pkg.sv ***
package ptp_pkg;
    // Register space chosen by the select bit
    typedef enum logic {
        PTP_SPACE_NORMAL,
        PTP_SPACE_TEST
    } ptp_space_t;
endpackage

// *** ptp_test_port.sv ***
`include "ptp_cfg.svh"

module ptp_test_port #(
    parameter int DEPTH = `PTP_DEPTH_DEFAULT
) (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      rstn,
    // Mode controls
    input  wire logic                      production_test_enable,
    input  wire logic                      scan_float_outputs,
    // Receive link data pins
    input  wire logic [`PTP_LINK_W-1:0]    receive_link_data,
    output logic      [`PTP_LINK_W-1:0]    core_receive_data,
    // Transmit link data pins
    input  wire logic [`PTP_LINK_W-1:0]    core_transmit_data,
    input  wire logic [`PTP_LINK_W-1:0]    transmit_link_data_i,
    output logic      [`PTP_LINK_W-1:0]    transmit_link_data_o,
    output logic      [`PTP_LINK_W-1:0]    transmit_link_data_oe
);

    localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int TOP_W = `PTP_ADDR_W - IDX_W;

    typedef struct packed {
        logic                                   wr_low;
        ptp_pkg::ptp_space_t                    wr_sel;
        logic [`PTP_ADDR_W-1:0]                 wr_addr;
        logic [`PTP_DATA_W-1:0]                 wr_data;
        logic [1:0][DEPTH-1:0][`PTP_DATA_W-1:0] regs;
        logic [`PTP_LINK_W-1:0]                 rx;
        logic [`PTP_LINK_W-1:0]                 tx;
        logic [`PTP_LINK_W-1:0]                 oe;
    } ptp_state_t;

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync_q;
    logic       rst_n_s;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'h1};
        end
    end
    assign rst_n_s = rst_sync_q[1];

    // ****************************************
    // Address decode
    // ****************************************
    // Words above the implemented depth read zero and ignore writes
    function automatic logic addr_hit(input logic [`PTP_ADDR_W-1:0] a);
        logic ok;
        ok = (TOP_W <= 0) || ((a >> IDX_W) == '0);
        if (int'(a[IDX_W-1:0]) >= DEPTH) begin
            ok = 1'h0;
        end
        return ok;
    endfunction

    ptp_state_t             s_q;
    ptp_state_t             s_d;
    logic                   in_test;
    logic                   rd_n;
    logic                   wr_n;
    logic                   read_act;
    logic                   commit;
    logic [`PTP_ADDR_W-1:0] pin_addr;
    logic                   pin_sel;
    logic [`PTP_DATA_W-1:0] rd_val;
    logic [`PTP_DATA_W-1:0] bus_in;

    always_comb begin
        in_test  = production_test_enable;
        rd_n     = in_test ? receive_link_data[`PTP_RD_STROBE_BIT] : 1'h1;
        wr_n     = in_test ? receive_link_data[`PTP_WR_STROBE_BIT] : 1'h1;
        pin_addr = receive_link_data[`PTP_ADDR_MSB:`PTP_ADDR_LSB];
        pin_sel  = receive_link_data[`PTP_SEL_BIT];
        bus_in   = transmit_link_data_i[`PTP_BUS_MSB:`PTP_BUS_LSB];
        // A colliding write wins; the bus stays released to avoid a fight
        read_act = !rd_n && wr_n;
        commit   = s_q.wr_low && wr_n;
        rd_val   = '0;
        if (addr_hit(pin_addr)) begin
            rd_val = s_q.regs[pin_sel][pin_addr[IDX_W-1:0]];
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d        = s_q;
        s_d.wr_low = !wr_n;
        // Latch every low cycle so the value on the bus at the rise is kept
        if (!wr_n) begin
            s_d.wr_sel  = ptp_pkg::ptp_space_t'(pin_sel);
            s_d.wr_addr = pin_addr;
            s_d.wr_data = bus_in;
        end
        if (commit && addr_hit(s_q.wr_addr)) begin
            s_d.regs[s_q.wr_sel][s_q.wr_addr[IDX_W-1:0]] = s_q.wr_data;
        end
        s_d.rx = receive_link_data;
        if (in_test) begin
            s_d.rx[`PTP_SEL_BIT:`PTP_ADDR_LSB] = '0;
        end
        s_d.tx = core_transmit_data;
        s_d.oe = `PTP_OE_RESET;
        if (in_test) begin
            s_d.tx[`PTP_BUS_MSB:`PTP_BUS_LSB] = rd_val;
            s_d.oe[`PTP_BUS_MSB:`PTP_BUS_LSB] = read_act ? '1 : '0;
        end
        if (scan_float_outputs) begin
            s_d.oe = '0;
        end
    end

    always_ff @(posedge clock or negedge rst_n_s) begin
        if (!rst_n_s) begin
            s_q    <= '0;
            s_q.tx <= `PTP_TX_RESET;
            s_q.oe <= `PTP_OE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign core_receive_data     = s_q.rx;
    assign transmit_link_data_o  = s_q.tx;
    assign transmit_link_data_oe = s_q.oe;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_quiet_mode;
        !in_test [*2];
    endsequence

    // Write walk: strobe held low, then seen high again
    sequence s_wr_held;
        in_test && !receive_link_data[`PTP_WR_STROBE_BIT];
    endsequence

    sequence s_wr_rise;
        in_test && receive_link_data[`PTP_WR_STROBE_BIT];
    endsequence

    property p_read_drive;
        @(posedge clock) disable iff (!rst_n_s)
        (read_act && !scan_float_outputs) |=>
            (transmit_link_data_o[`PTP_BUS_MSB:`PTP_BUS_LSB] == $past(rd_val)) &&
            (&transmit_link_data_oe[`PTP_BUS_MSB:`PTP_BUS_LSB]);
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read data not driven");

    property p_write_commit;
        @(posedge clock) disable iff (!rst_n_s)
        (commit && addr_hit(s_q.wr_addr)) |=>
            s_q.regs[$past(s_q.wr_sel)][$past(s_q.wr_addr[IDX_W-1:0])] == $past(s_q.wr_data);
    endproperty
    a_write_commit: assert property (p_write_commit) else $error("write not stored");

    property p_wr_walk;
        @(posedge clock) disable iff (!rst_n_s)
        s_wr_held ##1 s_wr_rise |-> commit;
    endproperty
    a_wr_walk: assert property (p_wr_walk) else $error("strobe rise did not commit");

    property p_wr_capture;
        @(posedge clock) disable iff (!rst_n_s)
        s_wr_held |=> (s_q.wr_data == $past(bus_in)) && (s_q.wr_addr == $past(pin_addr)) &&
            (s_q.wr_sel == $past(pin_sel));
    endproperty
    a_wr_capture: assert property (p_wr_capture) else $error("held write not captured");

    property p_rd_pin;
        @(posedge clock) disable iff (!rst_n_s)
        (in_test && !receive_link_data[`PTP_RD_STROBE_BIT] && receive_link_data[`PTP_WR_STROBE_BIT]
         && !scan_float_outputs) |=> (&transmit_link_data_oe[`PTP_BUS_MSB:`PTP_BUS_LSB]);
    endproperty
    a_rd_pin: assert property (p_rd_pin) else $error("pin 22 not read strobe");

    property p_rx_mux;
        @(posedge clock) disable iff (!rst_n_s)
        in_test |=> (core_receive_data[`PTP_SEL_BIT:`PTP_ADDR_LSB] == '0);
    endproperty
    a_rx_mux: assert property (p_rx_mux) else $error("test pins leak to core");

    property p_wr_pin;
        @(posedge clock) disable iff (!rst_n_s)
        s_quiet_mode |=> $stable(s_q.regs);
    endproperty
    a_wr_pin: assert property (p_wr_pin) else $error("write outside test mode");

    property p_bus_low;
        @(posedge clock) disable iff (!rst_n_s)
        (in_test && !scan_float_outputs) |=>
            (&transmit_link_data_oe[`PTP_BUS_LSB-1:0]) &&
            (transmit_link_data_o[`PTP_BUS_LSB-1:0] == $past(core_transmit_data[`PTP_BUS_LSB-1:0]));
    endproperty
    a_bus_low: assert property (p_bus_low) else $error("lower pins disturbed");

    property p_float;
        @(posedge clock) disable iff (!rst_n_s)
        scan_float_outputs |=> (transmit_link_data_oe == '0);
    endproperty
    a_float: assert property (p_float) else $error("outputs not floated");

    property p_normal;
        @(posedge clock) disable iff (!rst_n_s)
        (!in_test && !scan_float_outputs) |=>
            (&transmit_link_data_oe) && (transmit_link_data_o == $past(core_transmit_data));
    endproperty
    a_normal: assert property (p_normal) else $error("normal drive lost");

    property p_release;
        @(posedge clock) disable iff (!rst_n_s)
        (in_test && rd_n) |=> (transmit_link_data_oe[`PTP_BUS_MSB:`PTP_BUS_LSB] == '0);
    endproperty
    a_release: assert property (p_release) else $error("bus not released");

    // Both strobes low: write goes ahead, bus must stay released
    property p_collide;
        @(posedge clock) disable iff (!rst_n_s)
        (in_test && !receive_link_data[`PTP_RD_STROBE_BIT] && !receive_link_data[`PTP_WR_STROBE_BIT])
            |=> (transmit_link_data_oe[`PTP_BUS_MSB:`PTP_BUS_LSB] == '0);
    endproperty
    a_collide: assert property (p_collide) else $error("bus driven during collision");

endmodule

// *** ptp_tester.sv ***
// ****************
// Production tester model
// ****************
module ptp_tester (
    // Clock
    input  wire logic        clock,
    // Strobes, address and data drive
    output logic      [31:0] pins,
    output logic      [15:0] drv,
    output logic             drv_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        pins = 32'h00c00000;
        drv = 16'h0000;
        drv_oe = 1'b0;
    end
    // Kind 0 write, 1 read, 2 both strobes low on purpose
    task automatic access(input int kind, input logic sel, input logic [11:0] a,
                          input logic [15:0] d, input int hold);
        @(negedge clock);
        pins[24] = sel;
        pins[21:10] = a;
        drv = d;
        drv_oe = kind != 1;
        pins[23:22] = kind == 0 ? 2'b01 : kind == 1 ? 2'b10 : 2'b00;
        repeat (hold) @(negedge clock);
        pins[23:22] = 2'b11;
        // Data held one more cycle past the strobe rise
        @(negedge clock);
        drv_oe = 1'b0;
        @(negedge clock);
    endtask
endmodule

// *** tb.sv ***
// ****************
// Bench
// ****************
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock, rstn, test_en, scan_float, drv_oe, prev_oe;
    logic [31:0] core_tx, pins, tx_i, tx_o, tx_oe, core_rx;
    logic [15:0] drv, bus_last, lfsr_q, mem [8];
    logic [15:0] exp_q [$];
    int          fails, comparisons, cycles;
    // Released bus shows inverse of last level, no pull
    assign tx_i = {tx_oe[16] ? tx_o[31:16] : drv_oe ? drv : ~bus_last, tx_o[15:0]};
    ptp_test_port #(.DEPTH(16)) DUT (.clock(clock), .rstn(rstn), .production_test_enable(test_en),
        .scan_float_outputs(scan_float), .receive_link_data(pins), .core_receive_data(core_rx),
        .core_transmit_data(core_tx), .transmit_link_data_i(tx_i), .transmit_link_data_o(tx_o),
        .transmit_link_data_oe(tx_oe));
    ptp_tester tester (.clock(clock), .pins(pins), .drv(drv), .drv_oe(drv_oe));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic rd(input logic sel, input logic [11:0] a, input logic [15:0] want, input int hold);
        exp_q.push_back(want);
        tester.access(1, sel, a, 16'h0000, hold);
        check(tx_oe[31:16], 32'h0);
        check(exp_q.size(), 32'h0);
    endtask
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial bus_last = 16'h5a5a;
    always @(posedge clock) begin
        if (tx_oe[16] === 1'b1 || drv_oe) begin
            bus_last <= tx_i[31:16];
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end
    // Oldest note is taken when the read drive appears
    always @(negedge clock) begin
        if (test_en && !scan_float && tx_oe[16] === 1'b1 && !prev_oe) begin
            if (exp_q.size() == 0)
                check(tx_oe[16], 32'h0);
            else
                check(tx_o[31:16], exp_q.pop_front());
        end
        prev_oe = tx_oe[16] === 1'b1;
    end
    initial begin
        rstn = 1'b0;
        test_en = 1'b0;
        scan_float = 1'b0;
        lfsr_q = 16'h0061;
        core_tx = 32'h1234abcd;
        repeat (4) @(negedge clock);
        check(tx_o, 32'hffffffff);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        tester.access(0, 1'b1, 12'h001, 16'hbad0, 1);
        check(tx_o, core_tx);
        check(tx_oe, 32'hffffffff);
        check(core_rx, pins);
        $display("normal mode test done");
        test_en = 1'b1;
        core_tx = {lfsr_q, ~lfsr_q};
        repeat (3) @(negedge clock);
        check(core_rx[24:10], 32'h0);
        for (int i = 0; i < 8; i++) begin
            lfsr_q = lfsr(lfsr_q);
            mem[i] = lfsr_q;
            tester.access(0, i[0], 12'(15 - i), lfsr_q, 1 + i % 3);
        end
        for (int i = 0; i < 8; i++) rd(i[0], 12'(15 - i), mem[i], 1 + i % 4);
        rd(1'b1, 12'h001, 16'h0000, 1);
        check(tx_o[15:0], core_tx[15:0]);
        check(tx_oe[15:0], 32'hffff);
        $display("test access done");
        tester.access(0, 1'b0, 12'h01f, 16'hffff, 1);
        rd(1'b0, 12'h00f, mem[0], 2);
        rd(1'b0, 12'h01f, 16'h0000, 1);
        tester.access(2, 1'b0, 12'h003, 16'h5aa5, 2);
        rd(1'b0, 12'h003, 16'h5aa5, 1);
        $display("refusal test done");
        scan_float = 1'b1;
        repeat (2) @(negedge clock);
        check(tx_oe, 32'h0);
        $display("float test done");
        // Float kept on so the reset drive does not look like a read
        rstn = 1'b0;
        repeat (2) @(negedge clock);
        check(tx_o, 32'hffffffff);
        check(tx_oe, 32'hffffffff);
        check(core_rx, 32'h0);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        scan_float = 1'b0;
        repeat (2) @(negedge clock);
        rd(1'b1, 12'h00e, 16'h0000, 1);
        $display("reset test done");
        wrap_up();
    end
endmodule
